// ### hw/chc_pkg.sv
// Constants and types for the content-addressable memory host controller
package chc_pkg;
  localparam int CLK_PERIOD_NS = 100;
  localparam int T_SETUP_NS = 50;
  localparam int T_STROBE_NS = 200;
  localparam int T_RECOVER_NS = 100;
  localparam int SETUP_CYC = (T_SETUP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int STROBE_CYC = (T_STROBE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int RECOVER_CYC =
    (T_RECOVER_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // Avalon byte offsets
  localparam logic [4:0] REG_CMD = 5'h00;
  localparam logic [4:0] REG_WDATA = 5'h04;
  localparam logic [4:0] REG_RDATA = 5'h08;
  localparam logic [4:0] REG_STATUS = 5'h0C;
  localparam logic [4:0] REG_INSTR = 5'h10;

  // Command and instruction register fields
  localparam int CMD_AV_BIT = 12;
  localparam int CMD_WR_BIT = 13;
  localparam int CMD_VB_BIT = 14;
  localparam int CMD_SELA_BIT = 15;
  localparam int CMD_SELB_BIT = 16;
  localparam int INS_DATA_BIT = 13;
  localparam int INS_DREAD_BIT = 14;

  // Status register fields
  localparam int ST_BUSY = 0;
  localparam int ST_VB = 1;
  localparam int ST_MF = 2;
  localparam int ST_MV = 3;
  localparam int ST_MM = 4;
  localparam int ST_FF = 5;
  localparam int ST_TYPE_ERR = 6;
  localparam int ST_PEND = 7;
  localparam int ST_PEND_RD = 8;

  localparam logic [31:0] RST_WDATA = 32'h0000_0000;

  typedef struct packed {
    logic [11:0] ac;
    logic av;
    logic wr;
    logic vb_n;
    logic sel_a;
    logic sel_b;
  } chc_cmd_type;

  typedef struct packed {
    logic mf_n;
    logic mv_n;
    logic mm_n;
    logic ff_n;
  } chc_flags_type;

  typedef struct packed {
    logic ce_n;
    logic sel_a_n;
    logic sel_b_n;
    logic we_n;
    logic oe_n;
    logic av_n;
    logic [11:0] ac;
    logic [31:0] dq;
    logic dq_oe_n;
    logic vb;
    logic vb_oe_n;
  } chc_pins_type;

  localparam chc_pins_type PINS_IDLE = '{ce_n: 1'b1, sel_a_n: 1'b1,
    sel_b_n: 1'b1, we_n: 1'b1, oe_n: 1'b1, av_n: 1'b0, ac: 12'h000,
    dq: 32'h0000_0000, dq_oe_n: 1'b1, vb: 1'b1, vb_oe_n: 1'b1};
  localparam chc_flags_type FLAGS_IDLE = 4'hF;
endpackage

// ### hw/chc_cycle.sv
// One strobe-qualified pin cycle toward the memory device
module chc_cycle
  import chc_pkg::*;
(
  input wire logic mclk,
  input wire logic reset,
  input wire logic start,
  input chc_cmd_type cmd,
  input wire logic [31:0] wdata,
  input wire logic [31:0] dq_in,
  input wire logic vb_in,
  input chc_flags_type flags_in,
  output logic busy,
  output logic [31:0] rdata,
  output logic vb_rd,
  output chc_flags_type flags,
  output chc_pins_type pins
);
  typedef enum logic [1:0] {IDLE, SETUP, STROBE, RECOVER} chc_state_type;
  chc_state_type state, next_state;
  logic [3:0] cnt, next_cnt;
  logic [31:0] next_rdata;
  logic next_vb_rd;
  chc_flags_type next_flags;
  chc_pins_type next_pins;

  assign busy = (state != IDLE);

  always_comb
  begin
    next_state = state;
    next_cnt = cnt;
    next_pins = pins;
    next_rdata = rdata;
    next_vb_rd = vb_rd;
    next_flags = flags;
    unique case (state)
      IDLE:
        if (start)
        begin
          next_state = SETUP;
          next_cnt = 4'(SETUP_CYC - 1);
          next_pins.sel_a_n = ~cmd.sel_a;
          next_pins.sel_b_n = ~cmd.sel_b;
          next_pins.av_n = cmd.av;
          next_pins.ac = cmd.ac;
          next_pins.we_n = ~cmd.wr;
          next_pins.oe_n = cmd.wr;
          next_pins.dq = wdata;
          next_pins.dq_oe_n = ~cmd.wr;
          next_pins.vb = cmd.vb_n;
          next_pins.vb_oe_n = ~(cmd.wr & ~cmd.av);
        end
      SETUP:
        if (cnt == 4'h0)
        begin
          next_state = STROBE;
          next_cnt = 4'(STROBE_CYC - 1);
          next_pins.ce_n = 1'b0;
        end
        else
        begin
          next_cnt = cnt - 4'h1;
        end
      STROBE:
        if (cnt == 4'h0)
        begin
          next_state = RECOVER;
          next_cnt = 4'(RECOVER_CYC - 1);
          next_pins.ce_n = 1'b1;
          next_rdata = dq_in;
          next_vb_rd = vb_in;
        end
        else
        begin
          next_cnt = cnt - 4'h1;
        end
      RECOVER:
        if (cnt == 4'h0)
        begin
          next_state = IDLE;
          next_flags = flags_in;
          next_pins = PINS_IDLE;
        end
        else
        begin
          next_cnt = cnt - 4'h1;
        end
    endcase
  end

  always_ff @(posedge mclk)
  begin
    if (reset)
    begin
      state <= IDLE;
      cnt <= 4'h0;
      pins <= PINS_IDLE;
      rdata <= 32'h0000_0000;
      vb_rd <= 1'b1;
      flags <= FLAGS_IDLE;
    end
    else
    begin
      state <= next_state;
      cnt <= next_cnt;
      pins <= next_pins;
      rdata <= next_rdata;
      vb_rd <= next_vb_rd;
      flags <= next_flags;
    end
  end
endmodule

// ### hw/chc_top.sv
// Avalon-controlled host for the memory device's parallel port
module chc_top
  import chc_pkg::*;
(
  input wire logic mclk,
  input wire logic reset,
  input wire logic [4:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  output logic chip_enable_n,
  output logic select_a_n,
  output logic select_b_n,
  output logic write_enable_n,
  output logic output_enable_n,
  output logic address_valid_n,
  output logic [11:0] addr_ctrl_bus,
  input wire logic [31:0] data_bus_in,
  output logic [31:0] data_bus_out,
  output logic data_bus_oe_n,
  input wire logic validity_n_in,
  output logic validity_n_out,
  output logic validity_n_oe_n,
  input wire logic match_flag_n,
  input wire logic match_valid_n,
  input wire logic multi_match_n,
  input wire logic full_flag_n
);
  logic busy;
  logic [31:0] seq_rdata;
  logic seq_vb;
  chc_flags_type seq_flags;
  chc_flags_type flags_in;
  chc_pins_type pins;
  chc_cmd_type seq_cmd;
  logic [31:0] seq_wdata;
  logic start, is_instr, refuse;
  logic req, fire, accept;
  logic [31:0] wdata, next_wdata;
  logic pend, next_pend;
  logic pend_read, next_pend_read;
  logic type_err, next_type_err;
  logic [31:0] next_readdata;
  logic next_waitreq;
  logic [31:0] status;

  assign flags_in = '{mf_n: match_flag_n, mv_n: match_valid_n,
    mm_n: multi_match_n, ff_n: full_flag_n};

  always_comb
  begin
    status = 32'h0000_0000;
    status[ST_BUSY] = busy;
    status[ST_VB] = seq_vb;
    status[ST_MF] = seq_flags.mf_n;
    status[ST_MV] = seq_flags.mv_n;
    status[ST_MM] = seq_flags.mm_n;
    status[ST_FF] = seq_flags.ff_n;
    status[ST_TYPE_ERR] = type_err;
    status[ST_PEND] = pend;
    status[ST_PEND_RD] = pend_read;
  end

  always_comb
  begin
    req = avs_read | avs_write;
    fire = req & ~avs_waitrequest;
    accept = ~(avs_write & busy &
      ((avs_address == REG_CMD) | (avs_address == REG_INSTR)));
    next_waitreq = ~(req & avs_waitrequest & accept);
    next_readdata = avs_readdata;
    if (req & avs_waitrequest & accept & avs_read)
    begin
      unique case (avs_address)
        REG_CMD: next_readdata = 32'h0000_0000;
        REG_WDATA: next_readdata = wdata;
        REG_RDATA: next_readdata = seq_rdata;
        REG_STATUS: next_readdata = status;
        default: next_readdata = 32'h0000_0000;
      endcase
    end
  end

  always_comb
  begin
    start = 1'b0;
    is_instr = 1'b0;
    refuse = 1'b0;
    seq_cmd = '{ac: avs_writedata[11:0], av: avs_writedata[CMD_AV_BIT],
      wr: avs_writedata[CMD_WR_BIT], vb_n: avs_writedata[CMD_VB_BIT],
      sel_a: avs_writedata[CMD_SELA_BIT], sel_b: avs_writedata[CMD_SELB_BIT]};
    seq_wdata = wdata;
    next_wdata = wdata;
    next_pend = pend;
    next_pend_read = pend_read;
    next_type_err = type_err;
    if (fire & avs_write)
    begin
      unique case (avs_address)
        REG_CMD:
          // Data cycle against a held instruction must match its direction
          if (~seq_cmd.av & pend & (seq_cmd.wr == pend_read))
          begin
            refuse = 1'b1;
          end
          else
          begin
            start = 1'b1;
          end
        REG_WDATA: next_wdata = avs_writedata;
        REG_STATUS:
          if (avs_writedata[ST_TYPE_ERR])
          begin
            next_type_err = 1'b0;
          end
        REG_INSTR:
        begin
          start = 1'b1;
          is_instr = 1'b1;
          seq_cmd.ac = 12'h000;
          seq_cmd.av = 1'b1;
          seq_cmd.wr = 1'b1;
          seq_cmd.vb_n = 1'b1;
          seq_wdata = {19'h00000, avs_writedata[12:0]};
          next_pend = avs_writedata[INS_DATA_BIT];
          next_pend_read = avs_writedata[INS_DREAD_BIT];
        end
        default: next_wdata = wdata;
      endcase
    end
    if (refuse)
    begin
      next_type_err = 1'b1;
    end
  end

  always_ff @(posedge mclk)
  begin
    if (reset)
    begin
      avs_readdata <= 32'h0000_0000;
      avs_waitrequest <= 1'b1;
      wdata <= RST_WDATA;
      pend <= 1'b0;
      pend_read <= 1'b0;
      type_err <= 1'b0;
    end
    else
    begin
      avs_readdata <= next_readdata;
      avs_waitrequest <= next_waitreq;
      wdata <= next_wdata;
      pend <= next_pend;
      pend_read <= next_pend_read;
      type_err <= next_type_err;
    end
  end

  chc_cycle u_cycle (
    .mclk(mclk),
    .reset(reset),
    .start(start),
    .cmd(seq_cmd),
    .wdata(seq_wdata),
    .dq_in(data_bus_in),
    .vb_in(validity_n_in),
    .flags_in(flags_in),
    .busy(busy),
    .rdata(seq_rdata),
    .vb_rd(seq_vb),
    .flags(seq_flags),
    .pins(pins)
  );

  assign chip_enable_n = pins.ce_n;
  assign select_a_n = pins.sel_a_n;
  assign select_b_n = pins.sel_b_n;
  assign write_enable_n = pins.we_n;
  assign output_enable_n = pins.oe_n;
  assign address_valid_n = pins.av_n;
  assign addr_ctrl_bus = pins.ac;
  assign data_bus_out = pins.dq;
  assign data_bus_oe_n = pins.dq_oe_n;
  assign validity_n_out = pins.vb;
  assign validity_n_oe_n = pins.vb_oe_n;

  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (reset);

  a_instr_load: assert property (
    start & is_instr |=> address_valid_n & ~write_enable_n & ~data_bus_oe_n
      & (data_bus_out[12] == $past(avs_writedata[12])))
    else $error("instruction load cycle not driven as control write");
  a_type_refuse: assert property (
    refuse |=> ~busy & type_err ##1 ~busy)
    else $error("mismatched data cycle was not refused");
  a_ctrl_space: assert property (
    start & ~is_instr |=> address_valid_n == $past(avs_writedata[CMD_AV_BIT]))
    else $error("address valid level differs from command");
  a_select_held: assert property (
    ~chip_enable_n |-> $stable({select_a_n, select_b_n, address_valid_n}))
    else $error("select or space changed during strobe");
  a_read_release: assert property (
    $fell(chip_enable_n) & write_enable_n |-> data_bus_oe_n & ~output_enable_n)
    else $error("host drives data during read cycle");
  a_strobe_width: assert property (
    $fell(chip_enable_n) |-> ##1 ~chip_enable_n ##1 chip_enable_n ##1 ~busy)
    else $error("chip enable strobe or recovery has wrong length");

  c_instr_load: cover property (start & is_instr);
  c_data_read: cover property ($fell(chip_enable_n) & write_enable_n
    & ~address_valid_n);
  c_refused: cover property (refuse);
endmodule

// ### testbench/chc_cam_model.sv
// Behavioural pin model of the memory device behind the controller
module chc_cam_model
  import chc_pkg::*;
#(
  parameter logic [11:0] CMP_CODE = 12'h005
)
(
  input wire logic chip_enable_n,
  input wire logic select_a_n,
  input wire logic select_b_n,
  input wire logic write_enable_n,
  input wire logic output_enable_n,
  input wire logic address_valid_n,
  input wire logic [11:0] addr_ctrl_bus,
  input wire logic [31:0] data_bus,
  input wire logic validity_n,
  output logic [31:0] data_bus_rd,
  output logic validity_n_rd,
  output chc_flags_type flags
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [31:0] mem [4096];
  logic empty [4096];
  logic pend, drive, vb_q;
  logic [31:0] rd_q;
  logic [11:0] hit;
  chc_flags_type nxt;
  int n;
  initial
  begin
    pend = 1'b0;
    drive = 1'b0;
    vb_q = 1'b1;
    rd_q = '0;
    hit = 12'hFFF;
    flags = FLAGS_IDLE;
    nxt = FLAGS_IDLE;
    foreach (empty[i]) empty[i] = 1'b1;
  end
  // Released lines show the inverse of the last value
  assign data_bus_rd = (drive && !output_enable_n) ? rd_q : ~rd_q;
  assign validity_n_rd = (drive && !output_enable_n) ? vb_q : ~vb_q;
  always @(negedge chip_enable_n)
  begin
    if (!select_a_n || !select_b_n)
    begin
      if (address_valid_n && !write_enable_n)
        pend = (data_bus[11:0] == CMP_CODE);
      else if (address_valid_n)
      begin
        // Lone device is both highest and lowest priority
        rd_q = {12'h000, flags, 4'h0, hit};
        drive = 1'b1;
      end
      else if (pend)
      begin
        n = 0;
        hit = 12'hFFF;
        for (int i = 0; i < 4096; i++)
          if (!empty[i] && mem[i] == data_bus)
          begin
            if (n == 0)
              hit = 12'(i);
            n++;
          end
        nxt = {n == 0, n == 0, n < 2, 1'b1};
      end
      else if (!write_enable_n)
      begin
        mem[addr_ctrl_bus] = data_bus;
        empty[addr_ctrl_bus] = validity_n;
      end
      else
      begin
        rd_q = mem[addr_ctrl_bus];
        vb_q = empty[addr_ctrl_bus];
        drive = 1'b1;
      end
    end
  end
  // Flags move only after the strobe rises
  always @(posedge chip_enable_n)
    flags = nxt;
  always @(posedge output_enable_n)
    drive = 1'b0;
endmodule

// ### testbench/cam_host_control_vp_lookup_test.sv
// Self-checking bench for the memory device host controller
module cam_host_control_vp_lookup_test
  import chc_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  typedef struct packed {
    logic [11:0] a;
    logic [31:0] d;
    logic vb;
  } chc_row_type;
  logic mclk, reset, avs_read, avs_write, avs_waitrequest;
  logic [4:0] avs_address;
  logic [31:0] avs_writedata, avs_readdata, q;
  logic chip_enable_n, select_a_n, select_b_n, write_enable_n;
  logic output_enable_n, address_valid_n, data_bus_oe_n;
  logic [11:0] addr_ctrl_bus;
  logic [31:0] data_bus_out, dq_dev, dq_w;
  logic validity_n_out, validity_n_oe_n, vb_dev, vb_w;
  chc_flags_type fl;
  chc_row_type rows [4];
  logic [31:0] cv [3];
  logic [31:0] cs [3];
  logic [3:0] cf [3];
  int n_errors, checks;
  assign dq_w = data_bus_oe_n ? dq_dev : data_bus_out;
  assign vb_w = validity_n_oe_n ? vb_dev : validity_n_out;
  chc_top uut (.mclk, .reset, .avs_address, .avs_read, .avs_write,
    .avs_writedata, .avs_readdata, .avs_waitrequest, .chip_enable_n,
    .select_a_n, .select_b_n, .write_enable_n, .output_enable_n,
    .address_valid_n, .addr_ctrl_bus, .data_bus_in(dq_w), .data_bus_out,
    .data_bus_oe_n, .validity_n_in(vb_w), .validity_n_out,
    .validity_n_oe_n, .match_flag_n(fl.mf_n), .match_valid_n(fl.mv_n),
    .multi_match_n(fl.mm_n), .full_flag_n(fl.ff_n));
  chc_cam_model dev (.chip_enable_n, .select_a_n, .select_b_n,
    .write_enable_n, .output_enable_n, .address_valid_n, .addr_ctrl_bus,
    .data_bus(dq_w), .validity_n(vb_w), .data_bus_rd(dq_dev),
    .validity_n_rd(vb_dev), .flags(fl));
  initial
  begin
    mclk = 1'b0;
    forever #50 mclk = ~mclk;
  end
  task complete_run;
    $display("checks %0d mismatches %0d", checks, n_errors);
    if (n_errors == 0 && checks > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  task chk(input logic [31:0] got, input logic [31:0] exp, input string m);
    checks++;
    if (got !== exp)
    begin
      n_errors++;
      $display("[FAIL] %0t %s got %h expected %h", $time, m, got, exp);
    end
  endtask
  task chkb(input logic got, input logic exp, input string m);
    chk({31'h0, got}, {31'h0, exp}, m);
  endtask
  // One Avalon access, held until waitrequest is seen low
  task bus(input logic [4:0] a, input logic w, input logic [31:0] d);
    int k;
    k = 0;
    avs_address <= a;
    avs_write <= w;
    avs_read <= !w;
    avs_writedata <= d;
    do
    begin
      @(posedge mclk);
      k++;
    end
    while (avs_waitrequest !== 1'b0 && k < 100);
    q = avs_readdata;
    avs_write <= 1'b0;
    avs_read <= 1'b0;
    @(posedge mclk);
  endtask
  // Register write followed by polling until the pin cycle ends
  task op(input logic [4:0] a, input logic [31:0] d);
    int k;
    k = 0;
    bus(a, 1'b1, d);
    do
    begin
      bus(REG_STATUS, 1'b0, '0);
      k++;
    end
    while (q[ST_BUSY] !== 1'b0 && k < 20);
  endtask
  function automatic logic [31:0] mk(input logic [11:0] a,
    input logic av, wr, vb, sa, sb);
    return {15'h0000, sb, sa, vb, wr, av, a};
  endfunction
  initial
  begin
    repeat (5000) @(posedge mclk);
    n_errors++;
    complete_run();
  end
  initial
  begin
    reset = 1'b1;
    avs_address = '0;
    avs_read = 1'b0;
    avs_write = 1'b0;
    avs_writedata = '0;
    n_errors = 0;
    checks = 0;
    rows = '{'{12'h000, 32'h1234_5678, 1'b0},
      '{12'hFFF, 32'hFFFF_FFFF, 1'b0}, '{12'h123, 32'h0000_0000, 1'b1},
      '{12'h800, 32'h1234_5678, 1'b0}};
    cv = '{32'hFFFF_FFFF, 32'h1234_5678, 32'h0000_0000};
    cs = '{32'h0003_0FFF, 32'h0001_0000, 32'h000F_0FFF};
    cf = '{4'hC, 4'h8, 4'hF};
    repeat (6) @(posedge mclk);
    reset <= 1'b0;
    @(posedge mclk);
    chk({24'h0, chip_enable_n, select_a_n, select_b_n, write_enable_n,
      output_enable_n, address_valid_n, data_bus_oe_n, validity_n_oe_n},
      32'h0000_00FB, "idle pins");
    chk(avs_readdata, 32'h0000_0000, "readdata");
    $display("test reset done");
    foreach (rows[i])
    begin
      bus(REG_WDATA, 1'b1, rows[i].d);
      op(REG_CMD, mk(rows[i].a, 1'b0, 1'b1, rows[i].vb, 1'b1, 1'b0));
    end
    foreach (rows[i])
    begin
      op(REG_CMD, mk(rows[i].a, 1'b0, 1'b0, 1'b0, 1'b0, 1'b1));
      chkb(q[ST_VB], rows[i].vb, "validity");
      bus(REG_RDATA, 1'b0, '0);
      chk(q, rows[i].d, "memory read");
    end
    $display("test memory rows done");
    bus(REG_WDATA, 1'b1, 32'hDEAD_BEEF);
    op(REG_CMD, mk(12'h000, 1'b0, 1'b1, 1'b0, 1'b0, 1'b0));
    op(REG_CMD, mk(12'h000, 1'b0, 1'b0, 1'b0, 1'b1, 1'b0));
    bus(REG_RDATA, 1'b0, '0);
    chk(q, 32'h1234_5678, "unselected write");
    $display("test select done");
    op(REG_INSTR, 32'h0000_A005);
    chkb(q[ST_PEND], 1'b1, "pending");
    for (int i = 0; i < 3; i++)
    begin
      bus(REG_WDATA, 1'b1, cv[i]);
      op(REG_CMD, mk(12'h000, 1'b0, 1'b1, 1'b0, 1'b1, 1'b0));
      chk({28'h0, q[5:2]}, {28'h0, cf[i]}, "flags");
      op(REG_CMD, mk(12'h000, 1'b1, 1'b0, 1'b0, 1'b1, 1'b0));
      bus(REG_RDATA, 1'b0, '0);
      chk(q, cs[i], "device status");
    end
    $display("test compare done");
    op(REG_INSTR, 32'h0000_E005);
    op(REG_CMD, mk(12'h000, 1'b0, 1'b1, 1'b0, 1'b1, 1'b0));
    chkb(q[ST_TYPE_ERR], 1'b1, "type error");
    chkb(q[ST_PEND_RD], 1'b1, "expects read");
    bus(REG_STATUS, 1'b1, 32'h0000_0040);
    bus(REG_STATUS, 1'b0, '0);
    chkb(q[ST_TYPE_ERR], 1'b0, "error cleared");
    bus(5'h14, 1'b1, 32'hFFFF_FFFF);
    bus(5'h14, 1'b0, '0);
    chk(q, 32'h0000_0000, "unmapped");
    $display("test refusals done");
    reset <= 1'b1;
    repeat (2) @(posedge mclk);
    reset <= 1'b0;
    @(posedge mclk);
    chk({24'h0, chip_enable_n, select_a_n, select_b_n, write_enable_n,
      output_enable_n, address_valid_n, data_bus_oe_n, validity_n_oe_n},
      32'h0000_00FB, "idle pins again");
    bus(REG_STATUS, 1'b0, '0);
    chk(q, 32'h0000_003E, "status after reset");
    $display("test mid-run reset done");
    complete_run();
  end
endmodule
